// File: rtl/prd_bcd_to_bin.sv
/*
  Combinational BCD to binary converter for up to five digits.
  Assumes digits packed four bits each, least significant digit lowest; only
  the lowest count_in digits take part, and the top one of those may exceed
  nine, since the top position carries 0 to 15 on these boards.
*/
`timescale 1ns/1ps
`default_nettype none

module prd_bcd_to_bin (
  input  wire logic [19:0] digits_in,
  input  wire logic [2:0]  count_in,
  output logic      [16:0] value_out,
  output logic             bad_out
);

  always_comb begin
    value_out = 17'h00000;
    bad_out   = 1'b0;
    for (int i = 4; i >= 0; i--) begin
      if (i < int'(count_in)) begin
        value_out = 17'(value_out * 17'd10) + 17'(digits_in[i*4 +: 4]);
        // A lower digit above nine is a corrupt code, not a large number.
        if (i < int'(count_in) - 1 && digits_in[i*4 +: 4] > 4'h9) begin
          bad_out = 1'b1;
        end
      end
    end
  end

endmodule : prd_bcd_to_bin

`default_nettype wire

// File: rtl/prd_decoder.sv
/*
  Parallel reference decoder: samples the parallel reference lines, decodes
  them by format, width and display scaling into a signed, limited count, and
  offers setup and results over APB.
  Assumes the reference lines, sign and SET strobe are asynchronous pins, a
  single 200 MHz clock and a zero-wait APB master.
*/
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module prd_decoder (
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire logic [7:0]         paddr_in,
  input  wire logic               psel_in,
  input  wire logic               penable_in,
  input  wire logic               pwrite_in,
  input  wire logic [31:0]        pwdata_in,
  output logic      [31:0]        prdata_out,
  output logic                    pready_out,
  output logic                    pslverr_out,
  input  wire logic [15:0]        ref_data_in,
  input  wire logic               ref_sign_in,
  input  wire logic               ref_set_in,
  output prd_pkg::prd_ref_type    reference_monitor_out
);

  // Pin synchroniser, packed as {set, sign, data}.
  logic [17:0] pin_meta;
  logic [17:0] pin_sync;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta <= 18'h00000;
      pin_sync <= 18'h00000;
    end else begin
      pin_meta <= {ref_set_in, ref_sign_in, ref_data_in};
      pin_sync <= pin_meta;
    end
  end

  logic [15:0] data;
  logic        sign;
  logic        set_level;
  assign data      = pin_sync[15:0];
  assign sign      = pin_sync[16];
  assign set_level = pin_sync[17];

  // Registers and their next values.
  prd_pkg::prd_cfg_type cfg;
  prd_pkg::prd_cfg_type next_cfg;
  prd_pkg::prd_ref_type ref_q;
  prd_pkg::prd_ref_type next_ref_q;
  logic [31:0]          next_prdata;
  logic                 next_pslverr;

  // Decoder wires.
  logic                  rpm_mode;
  logic                  user_mode;
  logic                  is_bin;
  logic                  is_fmt6;
  logic                  is_bcd;
  logic [19:0]           bcd_digits;
  logic [2:0]            bcd_count;
  logic [16:0]           bcd_value;
  logic                  bcd_bad;
  logic [16:0]           bin_mag;
  logic                  bin_all_ones;
  logic [16:0]           mag;
  logic [16:0]           limit;
  logic [16:0]           full_scale;
  prd_pkg::prd_unit_type unit;
  logic                  cfg_err;
  logic                  clamped;
  logic [16:0]           mag_lim;
  logic signed [17:0]    value;

  prd_bcd_to_bin u_bcd (
    .digits_in (bcd_digits),
    .count_in  (bcd_count),
    .value_out (bcd_value),
    .bad_out   (bcd_bad)
  );

  // Mode selection and line mapping.
  always_comb begin
    rpm_mode  = !cfg.narrow && cfg.scale_top == 2'h0
                && cfg.scale_low >= prd_pkg::SCALE_RPM_MIN
                && cfg.scale_low <= prd_pkg::SCALE_RPM_MAX;
    user_mode = !cfg.narrow && cfg.scale_low >= prd_pkg::SCALE_USER_MIN;
    is_bin    = cfg.fmt == 3'h7 && !rpm_mode && !user_mode;
    is_fmt6   = cfg.fmt == 3'h6 && !rpm_mode && !user_mode;
    is_bcd    = !is_bin;
    // Code 6 is meaningless on the eight-line board and at 12-bit width.
    cfg_err   = is_fmt6 && (cfg.narrow || !cfg.wide16);
    bcd_digits = {4'h0, data};
    if (cfg.narrow) begin
      bcd_count = prd_pkg::DIGITS_NARROW;
    end else if (cfg.wide16) begin
      bcd_count = prd_pkg::DIGITS_WIDE16;
    end else begin
      bcd_count = prd_pkg::DIGITS_WIDE12;
    end
    if (is_fmt6) begin
      // Lowest digit steps by two; the sign line is the top data bit.
      bcd_digits = {2'b00, sign, data, 1'b0};
      bcd_count  = prd_pkg::DIGITS_FMT6;
    end
    if (cfg.narrow) begin
      bin_mag      = {9'h000, data[7:0]};
      bin_all_ones = &data[7:0];
    end else if (cfg.wide16) begin
      bin_mag      = {1'b0, data};
      bin_all_ones = &data;
    end else begin
      bin_mag      = {5'h00, data[11:0]};
      bin_all_ones = &data[11:0];
    end
  end

  // Step, limit and full scale per mode.
  always_comb begin
    mag        = is_bin ? bin_mag : bcd_value;
    limit      = prd_pkg::LIM_BCD12;
    full_scale = prd_pkg::FS_NONE;
    unit       = prd_pkg::PRD_UNIT_NONE;
    if (rpm_mode) begin
      unit  = prd_pkg::PRD_UNIT_RPM;
      limit = cfg.wide16 ? prd_pkg::LIM_BCD16 : prd_pkg::LIM_BCD12;
    end else if (user_mode) begin
      unit       = prd_pkg::PRD_UNIT_USER;
      full_scale = {3'b000, cfg.scale_low};
      limit      = cfg.wide16 ? {3'b000, cfg.scale_low} : prd_pkg::LIM_BCD12;
      if (cfg.wide16 && cfg.scale_low == prd_pkg::SCALE_X1000) begin
        full_scale = prd_pkg::FS_PCT001;
      end
    end else if (cfg.narrow) begin
      limit = prd_pkg::LIM_NARROW;
      unique case (cfg.fmt)
        3'h0: begin
          unit       = prd_pkg::PRD_UNIT_PCT1;
          full_scale = prd_pkg::FS_PCT1;
          limit      = prd_pkg::LIM_PCT1;
        end
        3'h1: begin
          unit       = prd_pkg::PRD_UNIT_PCT01;
          full_scale = prd_pkg::FS_PCT01;
        end
        3'h2: begin
          unit       = prd_pkg::PRD_UNIT_PCT001;
          full_scale = prd_pkg::FS_PCT001;
        end
        3'h3: unit = prd_pkg::PRD_UNIT_HZ1;
        3'h4: unit = prd_pkg::PRD_UNIT_HZ01;
        3'h5: unit = prd_pkg::PRD_UNIT_HZ001;
        3'h6: unit = prd_pkg::PRD_UNIT_NONE;
        3'h7: begin
          unit       = prd_pkg::PRD_UNIT_BIN;
          full_scale = prd_pkg::LIM_BIN8;
          limit      = prd_pkg::LIM_BIN8;
        end
      endcase
    end else begin
      unique case (cfg.fmt)
        3'h0: begin
          unit       = prd_pkg::PRD_UNIT_PCT1;
          full_scale = prd_pkg::FS_PCT1;
          limit      = prd_pkg::LIM_PCT1;
        end
        3'h1: begin
          unit       = prd_pkg::PRD_UNIT_PCT01;
          full_scale = prd_pkg::FS_PCT01;
          limit      = prd_pkg::LIM_PCT01;
        end
        3'h2: begin
          unit       = prd_pkg::PRD_UNIT_PCT001;
          full_scale = prd_pkg::FS_PCT001;
          limit      = cfg.wide16 ? prd_pkg::LIM_PCT001_16 : prd_pkg::LIM_BCD12;
        end
        3'h3: begin
          unit  = prd_pkg::PRD_UNIT_HZ1;
          limit = prd_pkg::LIM_HZ1;
        end
        3'h4: begin
          unit  = prd_pkg::PRD_UNIT_HZ01;
          limit = cfg.wide16 ? prd_pkg::LIM_HZ01_16 : prd_pkg::LIM_BCD12;
        end
        3'h5: begin
          unit  = prd_pkg::PRD_UNIT_HZ001;
          limit = cfg.wide16 ? prd_pkg::LIM_BCD16 : prd_pkg::LIM_BCD12;
        end
        3'h6: begin
          unit  = prd_pkg::PRD_UNIT_HZ001;
          limit = prd_pkg::LIM_FMT6;
        end
        3'h7: begin
          unit       = prd_pkg::PRD_UNIT_BIN;
          full_scale = cfg.wide16 ? prd_pkg::FS_BIN16 : prd_pkg::LIM_BIN12;
          limit      = cfg.wide16 ? prd_pkg::LIM_BIN16 : prd_pkg::LIM_BIN12;
        end
      endcase
    end
    // All ones means exactly 100 percent, not the raw count.
    if (is_bin && bin_all_ones) begin
      mag = full_scale;
    end
    clamped = mag > limit;
    mag_lim = clamped ? limit : mag;
    // Code 6 has no sign; its sign line was data.
    value   = (sign && !is_fmt6) ? -$signed({1'b0, mag_lim}) : $signed({1'b0, mag_lim});
  end

  // Reference register: updated while SET is high and decoding is enabled.
  always_comb begin
    next_ref_q = ref_q;
    if (cfg.enable && set_level) begin
      if (cfg_err) begin
        // The board does not operate: no reference at all.
        next_ref_q         = prd_pkg::REF_RESET;
        next_ref_q.cfg_err = 1'b1;
      end else if (is_bcd && bcd_bad) begin
        // Hold the last good value rather than decode a corrupt code.
        next_ref_q.digit_err = 1'b1;
      end else begin
        next_ref_q.value      = value;
        next_ref_q.full_scale = full_scale;
        next_ref_q.unit       = unit;
        next_ref_q.resolution = user_mode ? cfg.scale_top : 2'h0;
        next_ref_q.valid      = 1'b1;
        next_ref_q.digit_err  = 1'b0;
        next_ref_q.cfg_err    = 1'b0;
        next_ref_q.clamped    = clamped;
      end
    end
  end

  // APB slave: read data is latched in the setup cycle so it comes from a flop.
  always_comb begin
    next_cfg     = cfg;
    next_prdata  = prdata_out;
    next_pslverr = pslverr_out;
    if (psel_in && !penable_in) begin
      next_pslverr = 1'b0;
      next_prdata  = 32'h0000_0000;
      unique case (paddr_in)
        prd_pkg::ADDR_CTRL: begin
          next_prdata = {26'h0, cfg.enable, cfg.narrow, cfg.wide16, cfg.fmt};
        end
        prd_pkg::ADDR_SCALE: begin
          next_prdata = {16'h0, cfg.scale_top, cfg.scale_low};
        end
        prd_pkg::ADDR_REF: begin
          next_prdata = {{14{ref_q.value[17]}}, ref_q.value};
        end
        prd_pkg::ADDR_STATUS: begin
          next_prdata[prd_pkg::STAT_VALID_BIT]              = ref_q.valid;
          next_prdata[prd_pkg::STAT_DIGIT_BIT]              = ref_q.digit_err;
          next_prdata[prd_pkg::STAT_CFG_BIT]                = ref_q.cfg_err;
          next_prdata[prd_pkg::STAT_CLAMP_BIT]              = ref_q.clamped;
          next_prdata[prd_pkg::STAT_UNIT_LSB +: 4]          = ref_q.unit;
          next_prdata[prd_pkg::STAT_RES_LSB +: 2]           = ref_q.resolution;
          next_prdata[prd_pkg::STAT_SET_BIT]                = set_level;
        end
        prd_pkg::ADDR_FULL_SCALE: begin
          next_prdata = {15'h0, ref_q.full_scale};
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (psel_in && penable_in && pwrite_in) begin
      if (paddr_in == prd_pkg::ADDR_CTRL) begin
        next_cfg.fmt    = pwdata_in[prd_pkg::CTRL_FMT_LSB +: 3];
        next_cfg.wide16 = pwdata_in[prd_pkg::CTRL_WIDE16_BIT];
        next_cfg.narrow = pwdata_in[prd_pkg::CTRL_NARROW_BIT];
        next_cfg.enable = pwdata_in[prd_pkg::CTRL_ENABLE_BIT];
      end else if (paddr_in == prd_pkg::ADDR_SCALE) begin
        next_cfg.scale_low = pwdata_in[prd_pkg::SCALE_LOW_LSB +: 14];
        next_cfg.scale_top = pwdata_in[prd_pkg::SCALE_TOP_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg         <= '{fmt: prd_pkg::CTRL_RESET[2:0],
                       wide16: prd_pkg::CTRL_RESET[3],
                       narrow: prd_pkg::CTRL_RESET[4],
                       enable: prd_pkg::CTRL_RESET[5],
                       scale_low: prd_pkg::SCALE_RESET[13:0],
                       scale_top: prd_pkg::SCALE_RESET[15:14]};
      ref_q       <= prd_pkg::REF_RESET;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      cfg         <= next_cfg;
      ref_q       <= next_ref_q;
      prdata_out  <= next_prdata;
      pslverr_out <= next_pslverr;
    end
  end

  // Zero wait states: every access phase completes at once.
  assign pready_out            = psel_in && penable_in;
  assign reference_monitor_out = ref_q;

endmodule : prd_decoder

`default_nettype wire

// File: rtl/prd_pkg.sv
/*
  Constants and carrier types for the parallel reference decoder: register
  offsets, field positions, reset values, range limits and full-scale counts.
  Assumes a 32-bit APB with byte addresses on an 8-bit address bus.
*/
package prd_pkg;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_SCALE      = 8'h04;
  localparam logic [7:0] ADDR_REF        = 8'h08;
  localparam logic [7:0] ADDR_STATUS     = 8'h0c;
  localparam logic [7:0] ADDR_FULL_SCALE = 8'h10;

  // Control register fields.
  localparam int CTRL_FMT_LSB    = 0;
  localparam int CTRL_WIDE16_BIT = 3;
  localparam int CTRL_NARROW_BIT = 4;
  localparam int CTRL_ENABLE_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h28;

  // Scaling register fields: four low digits as binary, top digit in two bits.
  localparam int SCALE_LOW_LSB = 0;
  localparam int SCALE_TOP_LSB = 14;
  localparam logic [15:0] SCALE_RESET = 16'h0000;

  // Status register fields.
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_DIGIT_BIT = 1;
  localparam int STAT_CFG_BIT   = 2;
  localparam int STAT_CLAMP_BIT = 3;
  localparam int STAT_UNIT_LSB  = 4;
  localparam int STAT_RES_LSB   = 8;
  localparam int STAT_SET_BIT   = 10;

  // Display-scaling thresholds.
  localparam logic [13:0] SCALE_RPM_MIN  = 14'h0002;
  localparam logic [13:0] SCALE_RPM_MAX  = 14'h0027;
  localparam logic [13:0] SCALE_USER_MIN = 14'h0028;
  localparam logic [13:0] SCALE_X1000    = 14'h03e8;

  // Digit counts per board and width, and for code 6.
  localparam logic [2:0] DIGITS_NARROW = 3'h2;
  localparam logic [2:0] DIGITS_WIDE12 = 3'h3;
  localparam logic [2:0] DIGITS_WIDE16 = 3'h4;
  localparam logic [2:0] DIGITS_FMT6   = 3'h5;

  // Magnitude limits in counts of the active step.
  localparam logic [16:0] LIM_PCT1      = 17'h0006e;  // 110
  localparam logic [16:0] LIM_PCT01     = 17'h0044c;  // 1100
  localparam logic [16:0] LIM_BCD12     = 17'h0063f;  // 1599
  localparam logic [16:0] LIM_PCT001_16 = 17'h02af8;  // 11000
  localparam logic [16:0] LIM_HZ1       = 17'h00190;  // 400
  localparam logic [16:0] LIM_HZ01_16   = 17'h00fa0;  // 4000
  localparam logic [16:0] LIM_BCD16     = 17'h03e7f;  // 15999
  localparam logic [16:0] LIM_FMT6      = 17'h09c3e;  // 39998
  localparam logic [16:0] LIM_BIN12     = 17'h00fff;  // 4095
  localparam logic [16:0] LIM_BIN16     = 17'h080e8;  // 33000
  localparam logic [16:0] LIM_NARROW    = 17'h0009f;  // 159
  localparam logic [16:0] LIM_BIN8      = 17'h000ff;  // 255

  // Counts that stand for 100 percent, and zero where there is no full scale.
  localparam logic [16:0] FS_PCT1   = 17'h00064;  // 100
  localparam logic [16:0] FS_PCT01  = 17'h003e8;  // 1000
  localparam logic [16:0] FS_PCT001 = 17'h02710;  // 10000
  localparam logic [16:0] FS_BIN16  = 17'h07530;  // 30000
  localparam logic [16:0] FS_NONE   = 17'h00000;

  typedef enum logic [3:0] {
    PRD_UNIT_NONE,
    PRD_UNIT_PCT1,
    PRD_UNIT_PCT01,
    PRD_UNIT_PCT001,
    PRD_UNIT_HZ1,
    PRD_UNIT_HZ01,
    PRD_UNIT_HZ001,
    PRD_UNIT_BIN,
    PRD_UNIT_RPM,
    PRD_UNIT_USER
  } prd_unit_type;

  typedef struct packed {
    logic [2:0]  fmt;
    logic        wide16;
    logic        narrow;
    logic        enable;
    logic [13:0] scale_low;
    logic [1:0]  scale_top;
  } prd_cfg_type;

  typedef struct packed {
    logic signed [17:0] value;
    logic [16:0]        full_scale;
    prd_unit_type       unit;
    logic [1:0]         resolution;
    logic               valid;
    logic               digit_err;
    logic               cfg_err;
    logic               clamped;
  } prd_ref_type;

  localparam prd_ref_type REF_RESET = '{
    value: 18'sh00000, full_scale: 17'h00000, unit: PRD_UNIT_NONE,
    resolution: 2'h0, valid: 1'b0, digit_err: 1'b0, cfg_err: 1'b0,
    clamped: 1'b0};

endpackage : prd_pkg

// File: test/prd_decoder_props.sv
/*
  Port checker for the parallel reference decoder.
  Assumes it is bound to prd_decoder and sees its single clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none

module prd_decoder_props (
  input wire logic                 clk_in,
  input wire logic                 rst_n_in,
  input wire logic                 psel_in,
  input wire logic                 penable_in,
  input wire logic                 pready_out,
  input wire logic                 ref_set_in,
  input wire prd_pkg::prd_ref_type reference_monitor_out
);
  prd_pkg::prd_ref_type m;
  logic signed [17:0]   mag;

  assign m   = reference_monitor_out;
  assign mag = (m.value < 18'sh00000) ? -m.value : m.value;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_pct1; m.unit == prd_pkg::PRD_UNIT_PCT1 |-> mag <= 18'sh0006e; endproperty
  a_pct1: assert property (p_pct1) else $error("whole percent beyond limit");
  property p_pct01; m.unit == prd_pkg::PRD_UNIT_PCT01 |-> mag <= 18'sh0044c; endproperty
  a_pct01: assert property (p_pct01) else $error("tenth percent beyond limit");
  property p_pct001; m.unit == prd_pkg::PRD_UNIT_PCT001 |-> mag <= 18'sh02af8; endproperty
  a_pct001: assert property (p_pct001) else $error("hundredth percent beyond limit");
  property p_hz1; m.unit == prd_pkg::PRD_UNIT_HZ1 |-> mag <= 18'sh00190; endproperty
  a_hz1: assert property (p_hz1) else $error("whole hertz beyond limit");
  property p_hz01; m.unit == prd_pkg::PRD_UNIT_HZ01 |-> mag <= 18'sh00fa0; endproperty
  a_hz01: assert property (p_hz01) else $error("tenth hertz beyond limit");
  property p_hz001; m.unit == prd_pkg::PRD_UNIT_HZ001 |-> mag <= 18'sh09c3e; endproperty
  a_hz001: assert property (p_hz001) else $error("hundredth hertz beyond limit");
  property p_bin;
    m.unit == prd_pkg::PRD_UNIT_BIN |-> mag <= 18'sh080e8 &&
      (m.full_scale == 17'h00fff || m.full_scale == 17'h07530 || m.full_scale == 17'h000ff);
  endproperty
  a_bin: assert property (p_bin) else $error("binary value or full scale wrong");
  property p_rpm; m.unit == prd_pkg::PRD_UNIT_RPM |-> mag <= 18'sh03e7f && m.full_scale == 17'h0; endproperty
  a_rpm: assert property (p_rpm) else $error("rpm value beyond limit");
  property p_res; m.unit != prd_pkg::PRD_UNIT_USER |-> m.resolution == 2'h0; endproperty
  a_res: assert property (p_res) else $error("resolution set outside user scale");
  property p_cfg; m.cfg_err |-> !m.valid && m.value == 18'sh00000; endproperty
  a_cfg: assert property (p_cfg) else $error("refused format still shows a value");
  property p_bad; $rose(m.digit_err) |-> $stable(m.value); endproperty
  a_bad: assert property (p_bad) else $error("bad digit changed the value");
  // The strobe passes two flops, so three low samples must freeze the output.
  property p_hold; (!ref_set_in) [*3] |=> $stable(m); endproperty
  a_hold: assert property (p_hold) else $error("output moved while strobe low");
  property p_ready; pready_out == (psel_in && penable_in); endproperty
  a_ready: assert property (p_ready) else $error("ready not in access phase");

  c_bad: cover property (m.digit_err);
  c_cfg: cover property (m.cfg_err);
  c_user: cover property (m.unit == prd_pkg::PRD_UNIT_USER);
  c_clamp: cover property (m.clamped);
endmodule : prd_decoder_props

`default_nettype wire

// File: test/prd_ref_source.sv
/*
  Model of the external controller that drives the parallel reference lines.
  Assumes the bench calls put from its main process on the shared clock.
*/
`timescale 1ns/1ps
`default_nettype none

module prd_ref_source (
  input  wire logic        clk_in,
  output var  logic [15:0] ref_data_out,
  output var  logic        ref_sign_out,
  output var  logic        ref_set_out
);
  initial begin
    ref_data_out = 16'h0000;
    ref_sign_out = 1'b0;
    ref_set_out  = 1'b0;
  end

  // The strobe drops before the lines move and rises only after they settle,
  // so the decoder never samples a half-changed word; slow adds settle time.
  task automatic put(input logic [15:0] d, input logic s, input int slow);
    @(posedge clk_in);
    ref_set_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    ref_data_out <= d;
    ref_sign_out <= s;
    repeat (3 + slow) @(posedge clk_in);
    ref_set_out <= 1'b1;
  endtask : put
endmodule : prd_ref_source

`default_nettype wire

// File: test/test_prd_decoder.sv
/*
  Self-checking bench for the parallel reference decoder.
  Assumes an APB slave that raises pready in its own time and the register
  map of prd_pkg.
*/
`timescale 1ns/1ps
`default_nettype none

module test_prd_decoder;
  logic                 clk_in   = 1'b0;
  logic                 rst_n_in = 1'b0;
  logic [7:0]           paddr    = 8'h00;
  logic                 psel     = 1'b0;
  logic                 penable  = 1'b0;
  logic                 pwrite   = 1'b0;
  logic [31:0]          pwdata   = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [15:0]          data;
  logic                 sign;
  logic                 set;
  prd_pkg::prd_ref_type mon;
  int                   miscompares = 0;
  int                   n_tests     = 0;
  localparam int LIM [3][6] = '{'{110, 1100, 1599, 400, 1599, 1599},
    '{110, 1100, 11000, 400, 4000, 15999}, '{110, 159, 159, 159, 159, 159}};
  localparam int LIMB [3] = '{4095, 33000, 255};
  localparam logic [15:0] ONES [3] = '{16'h0fff, 16'hffff, 16'h00ff};
  localparam int FS [3] = '{4095, 30000, 255};

  always #2.5 clk_in = ~clk_in;

  prd_decoder u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .ref_data_in(data), .ref_sign_in(sign),
    .ref_set_in(set), .reference_monitor_out(mon));

  prd_ref_source u_src (.clk_in(clk_in), .ref_data_out(data), .ref_sign_out(sign),
    .ref_set_out(set));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_in);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave's answer.
    do @(posedge clk_in); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic cfg(input logic [5:0] c, input logic [15:0] sc);
    logic [31:0] q;
    logic        e;
    apb(1'b1, prd_pkg::ADDR_CTRL, {26'h0, c}, q, e);
    apb(1'b1, prd_pkg::ADDR_SCALE, {16'h0, sc}, q, e);
    // The new settings reach the monitor one edge after the write lands.
    repeat (2) @(negedge clk_in);
  endtask : cfg

  task automatic run(input logic [15:0] d, input logic s);
    u_src.put(d, s, $urandom % 4);
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
  endtask : run

  task automatic look(input logic signed [17:0] ev, input logic [3:0] eu);
    chk(32'(mon.value), 32'(ev));
    chk(32'(mon.unit), 32'(eu));
  endtask : look

  function automatic logic [19:0] rnd_bcd(input int n, input int tmax);
    logic [19:0] d;
    d = 20'h0;
    for (int i = 0; i < n; i++) d[4*i+:4] = 4'($urandom % 10);
    d[4*(n-1)+:4] = 4'($urandom % tmax);
    return d;
  endfunction : rnd_bcd

  function automatic logic signed [17:0] bcd_exp(input logic [19:0] d, input int n,
                                                 input int lim, input logic s);
    int v;
    v = 0;
    for (int i = n - 1; i >= 0; i--) v = v * 10 + d[4*i+:4];
    if (v > lim) v = lim;
    return 18'(s ? -v : v);
  endfunction : bcd_exp

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial begin : watchdog
    repeat (20000) @(posedge clk_in);
    miscompares++;
    end_of_test();
  end

  initial begin : main
    logic [31:0] q;
    logic        e;
    logic [19:0] d;
    logic        s;
    int          n;
    int          v;
    void'($urandom(32'ha508));
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    apb(1'b0, prd_pkg::ADDR_CTRL, 32'h0, q, e);
    chk(q, 32'h0000_0028);
    apb(1'b0, prd_pkg::ADDR_SCALE, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b1, prd_pkg::ADDR_REF, 32'h0000_0055, q, e);
    chk({31'h0, e}, 32'h0);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    $display("register test done");
    for (int b = 0; b < 3; b++) for (int f = 0; f < 6; f++) repeat (3) begin
      n = (b == 2) ? 2 : b + 3;
      cfg({1'b1, b == 2, b == 1, 3'(f)}, 16'h0);
      d = rnd_bcd(n, 16);
      s = 1'($urandom % 2);
      run(d[15:0], s);
      look(bcd_exp(d, n, LIM[b][f], s), 4'(f + 1));
    end
    $display("signed digit test done");
    d = rnd_bcd(5, 4);
    d[0] = 1'b0;
    d[17] = 1'b1;
    cfg(6'h2e, 16'h0);
    run(d[16:1], d[17]);
    look(bcd_exp(d, 5, 39998, 1'b0), 4'h6);
    cfg(6'h26, 16'h0);
    chk({31'h0, mon.cfg_err}, 32'h1);
    cfg(6'h36, 16'h0);
    chk({30'h0, mon.cfg_err, mon.valid}, 32'h2);
    $display("unsigned digit test done");
    for (int b = 0; b < 3; b++) begin
      cfg({1'b1, b == 2, b == 1, 3'h7}, 16'h0);
      run(ONES[b], 1'b0);
      look(18'(FS[b]), 4'h7);
      chk(32'(mon.full_scale), 32'(FS[b]));
      v = $urandom % LIMB[b];
      s = 1'($urandom % 2);
      run(16'(v), s);
      look(18'(s ? -v : v), 4'h7);
    end
    $display("binary test done");
    d = rnd_bcd(4, 16);
    cfg(6'h28, 16'h001e);
    run(d[15:0], 1'b1);
    look(bcd_exp(d, 4, 15999, 1'b1), 4'h8);
    cfg(6'h28, 16'h9388);
    look(bcd_exp(d, 4, 5000, 1'b1), 4'h9);
    chk({30'h0, mon.resolution}, 32'h2);
    chk(32'(mon.full_scale), 32'd5000);
    cfg(6'h28, 16'hc3e8);
    look(bcd_exp(d, 4, 1000, 1'b1), 4'h9);
    chk(32'(mon.full_scale), 32'd10000);
    $display("scaling test done");
    cfg(6'h28, 16'h0);
    run(16'h0099, 1'b0);
    run(16'h00a9, 1'b0);
    look(18'sh00063, 4'h1);
    chk({31'h0, mon.digit_err}, 32'h1);
    apb(1'b0, prd_pkg::ADDR_REF, 32'h0, q, e);
    chk(q, 32'h0000_0063);
    apb(1'b0, prd_pkg::ADDR_STATUS, 32'h0, q, e);
    chk(q, 32'h0000_0413);
    apb(1'b0, prd_pkg::ADDR_FULL_SCALE, 32'h0, q, e);
    chk(q, 32'h0000_0064);
    $display("bad digit test done");
    end_of_test();
  end
endmodule : test_prd_decoder

bind prd_decoder prd_decoder_props u_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
  .ref_set_in(ref_set_in), .reference_monitor_out(reference_monitor_out));

`default_nettype wire
